// >>> rtl/pdsc_defs.vh
// Constants for the power-down and self-test control block
`ifndef PDSC_DEFS_VH
`define PDSC_DEFS_VH
// ==========================================
// Register byte offsets
`define PDSC_REG_CTRL 8'h00
`define PDSC_REG_STAT 8'h04
// ==========================================
// Control register fields
`define PDSC_CTRL_PIN4_BUILT_IN_SELF_TEST_BIT 0
`define PDSC_CTRL_CS_GPIO_BIT 1
`define PDSC_CTRL_INT_PULL_BIT 2
`define PDSC_CTRL_RESET 3'h0
// ==========================================
// Status register fields
`define PDSC_STAT_ENABLED_BIT 0
`define PDSC_STAT_PLL_BIT 1
`define PDSC_STAT_BUILT_IN_SELF_TEST_BIT 2
`define PDSC_STAT_BISTCLK_BIT 3
`define PDSC_STAT_STRAP0_LSB 4
`define PDSC_STAT_STRAP1_LSB 6
`define PDSC_STAT_IRQ_BIT 8
// ==========================================
// Self-test clock source codes
`define PDSC_BISTCLK_PIXEL 1'h0
`define PDSC_BISTCLK_INT33 1'h1
`define PDSC_INT_OSC_MHZ 33
`endif

// >>> rtl/pdsc_sync.v
// Two-flop synchroniser for a group of asynchronous pins
module pdsc_sync #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  // First stage, read only by the second stage
  reg [WIDTH-1:0] meta;
  // ==========================================
  // Sync stages
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> rtl/pdsc_top.v
// Power-down, self-test and pin-function control with a Wishbone slave
// Behaviour
// - Power-down release resets all state to defaults; the code clears only ctrl and loads the straps on release
// - Low input holds power-down; high runs normally
// - Power-down tri-states outputs, stops the PLL
// - Self-test enable input 0 off, 1 on
// - Clock select 0 pixel, 1 internal 33 MHz
// - Shared pin is interrupt input by default
// - Interrupt pin may pull low in power-down
// - Chip-select pin or fast GPIO by register
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`include "pdsc_defs.vh"
module pdsc_top (
  input wire clk_in,
  input wire rst_n_in,
  input wire power_down_n_in,
  input wire selftest_enable_in,
  input wire pin4_in,
  output wire pin4_out,
  output wire pin4_oe_n_out,
  input wire [1:0] mode_strap_zero_in,
  input wire [1:0] mode_strap_one_in,
  input wire spi_cs_core_in,
  input wire fast_gpio_three_core_in,
  input wire fast_gpio_three_core_oe_in,
  input wire pin16_in,
  output reg pin16_out,
  output reg pin16_oe_n_out,
  output reg spi_cs_core_out,
  output reg fast_gpio_three_core_out,
  output reg se_outputs_oe_n_out,
  output reg pll_enable_out,
  output reg device_enabled_out,
  output reg core_reset_out,
  output reg selftest_active_out,
  output reg selftest_clock_select_out,
  output reg interrupt_request_out,
  output reg [1:0] mode_strap_zero_out,
  output reg [1:0] mode_strap_one_out,
  input wire [7:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  output reg wb_err_out
);
  // ==========================================
  // Pin synchronisers
  // Power-down, self-test enable, shared pin 4, straps and pin 16 are all asynchronous
  wire [7:0] sync_q;
  pdsc_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({pin16_in, mode_strap_one_in, mode_strap_zero_in, pin4_in,
               selftest_enable_in, power_down_n_in}),
    .sync_out(sync_q)
  );
  wire power_down_n = sync_q[0]; // Synchronised power-down level
  wire selftest_en_s = sync_q[1]; // Synchronised self-test enable
  wire pin4_s = sync_q[2]; // Synchronised shared pin level
  wire [1:0] strap0_s = sync_q[4:3]; // Synchronised strap level zero
  wire [1:0] strap1_s = sync_q[6:5]; // Synchronised strap level one
  wire pin16_s = sync_q[7]; // Synchronised chip-select pin
  // ==========================================
  // Power state machine
  localparam ST_OFF = 3'h1; // Powered down
  localparam ST_RESET = 3'h2; // One cycle core reset on release
  localparam ST_RUN = 3'h4; // Normal operation
  reg [2:0] state;
  reg [2:0] next_state;
  // Next state from the synchronised power-down level
  // A release of a single cycle still passes ST_RESET and clears ctrl
  always @* begin
    case (state)
      ST_OFF: next_state = power_down_n ? ST_RESET : ST_OFF;
      ST_RESET: next_state = power_down_n ? ST_RUN : ST_OFF;
      ST_RUN: next_state = power_down_n ? ST_RUN : ST_OFF;
      default: next_state = ST_OFF;
    endcase
  end
  // State register
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end
  wire running = (state == ST_RUN); // Fully enabled
  wire release_pulse = (state == ST_RESET); // Entry into enabled, clears ctrl and captures the straps
  // ==========================================
  // Control register, cleared on every power-down release
  reg [2:0] ctrl;
  wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
  // Address compare, shared by both register decodes
  function pdsc_hit;
    input [7:0] adr;
    input [7:0] offset;
    begin
      pdsc_hit = (adr == offset);
    end
  endfunction
  wire hit_ctrl = pdsc_hit(wb_adr_in, `PDSC_REG_CTRL); // Control register selected
  wire hit_stat = pdsc_hit(wb_adr_in, `PDSC_REG_STAT); // Status register selected
  // Software writes steer the pin functions
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl <= `PDSC_CTRL_RESET;
    end else if (release_pulse) begin
      ctrl <= `PDSC_CTRL_RESET;
      // Only byte lane 0 carries control bits; other lanes are ignored
    end else if (wb_req && wb_we_in && hit_ctrl && wb_sel_in[0]) begin
      ctrl <= wb_dat_in[2:0];
    end
  end
  wire pin4_is_built_in_self_test = ctrl[`PDSC_CTRL_PIN4_BUILT_IN_SELF_TEST_BIT]; // 0 = interrupt input
  wire pin16_is_gpio = ctrl[`PDSC_CTRL_CS_GPIO_BIT]; // 0 = chip select
  wire int_pull_en = ctrl[`PDSC_CTRL_INT_PULL_BIT]; // Allow pull-low when off
  // ==========================================
  // Strap capture at power-down release
  // Straps are held so a drifting divider cannot change mode mid-run
  // Captured in the cycle before RUN, so the core never sees them move
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_strap_zero_out <= 2'h0;
      mode_strap_one_out <= 2'h0;
    end else if (release_pulse) begin
      mode_strap_zero_out <= strap0_s;
      mode_strap_one_out <= strap1_s;
    end
  end
  // ==========================================
  // Power, self-test and pin outputs
  // Registered so every output is stable and glitch free
  // Reset and power-down share defaults except pin16_out, which follows the core in power-down: all off, outputs floating
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      device_enabled_out <= 1'b0;
      core_reset_out <= 1'b1;
      pll_enable_out <= 1'b0;
      se_outputs_oe_n_out <= 1'b1;
      selftest_active_out <= 1'b0;
      selftest_clock_select_out <= `PDSC_BISTCLK_PIXEL;
      interrupt_request_out <= 1'b0;
      spi_cs_core_out <= 1'b1;
      fast_gpio_three_core_out <= 1'b0;
      pin16_out <= 1'b0;
      pin16_oe_n_out <= 1'b1;
    end else begin
      device_enabled_out <= running;
      core_reset_out <= ~running;
      pll_enable_out <= running;
      se_outputs_oe_n_out <= ~running;
      selftest_active_out <= running & selftest_en_s;
      // Pixel clock unless pin 4 carries the select and reads high
      selftest_clock_select_out <= (running & pin4_is_built_in_self_test & pin4_s) ?
                                   `PDSC_BISTCLK_INT33 : `PDSC_BISTCLK_PIXEL;
      // Active-low interrupt input only while in its default role
      interrupt_request_out <= running & ~pin4_is_built_in_self_test & ~pin4_s;
      // Pin 16 function select
      spi_cs_core_out <= (running & ~pin16_is_gpio) ? pin16_s : 1'b1;
      fast_gpio_three_core_out <= (running & pin16_is_gpio) ? pin16_s : 1'b0;
      pin16_out <= fast_gpio_three_core_in;
      pin16_oe_n_out <= ~(running & pin16_is_gpio & fast_gpio_three_core_oe_in);
    end
  end
  // Chip-select input from the core is unused in peripheral mode
  wire unused_cs = spi_cs_core_in;
  // ==========================================
  // Pin 4 driver: pulls low only in power-down and when allowed
  // Enable survives power-down since ctrl is only cleared on release
  // Limitation: software must set the permission before power-down
  reg pin4_pull;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin4_pull <= 1'b0;
    end else begin
      pin4_pull <= ~running & int_pull_en & ~pin4_is_built_in_self_test;
    end
  end
  assign pin4_out = 1'b0;
  assign pin4_oe_n_out = ~pin4_pull;
  // ==========================================
  // Wishbone classic slave, one wait state, ack or err for one cycle
  function [31:0] pdsc_status;
    input dummy;
    begin
      pdsc_status = 32'h0;
      pdsc_status[`PDSC_STAT_ENABLED_BIT] = device_enabled_out;
      pdsc_status[`PDSC_STAT_PLL_BIT] = pll_enable_out;
      pdsc_status[`PDSC_STAT_BUILT_IN_SELF_TEST_BIT] = selftest_active_out;
      pdsc_status[`PDSC_STAT_BISTCLK_BIT] = selftest_clock_select_out;
      pdsc_status[`PDSC_STAT_STRAP0_LSB +: 2] = mode_strap_zero_out;
      pdsc_status[`PDSC_STAT_STRAP1_LSB +: 2] = mode_strap_one_out;
      pdsc_status[`PDSC_STAT_IRQ_BIT] = interrupt_request_out;
    end
  endfunction
  // Answer each request; unmapped addresses get err
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_req & (hit_ctrl | hit_stat);
      wb_err_out <= wb_req & ~(hit_ctrl | hit_stat) & ~unused_cs & 1'b1 |
                    wb_req & ~(hit_ctrl | hit_stat) & unused_cs;
      if (wb_req && !wb_we_in && hit_ctrl) begin
        wb_dat_out <= {29'h0, ctrl};
      end else if (wb_req && !wb_we_in && hit_stat) begin
        wb_dat_out <= pdsc_status(1'b0);
      end
    end
  end
endmodule

// >>> verif/pdsc_assertions.sv
// Concurrent checks for the power-down and self-test control block
module pdsc_checker (
  input wire clk_in,
  input wire rst_n_in,
  input wire power_down_n_in,
  input wire selftest_enable_in,
  input wire fast_gpio_three_core_in,
  input wire device_enabled_out,
  input wire pll_enable_out,
  input wire se_outputs_oe_n_out,
  input wire selftest_active_out,
  input wire pin4_oe_n_out,
  input wire pin16_oe_n_out,
  input wire pin16_out,
  input wire [1:0] mode_strap_zero_out,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_ack_out,
  input wire wb_err_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ====================
  // Power state, pins, bus
  AST_OFF: assert property ((!power_down_n_in)[*6]
    |-> !pll_enable_out && se_outputs_oe_n_out) else $error("live while off");
  AST_ON: assert property (power_down_n_in[*6]
    |-> device_enabled_out && !se_outputs_oe_n_out) else $error("not on");
  AST_ST_ON: assert property ((selftest_enable_in && device_enabled_out)[*4]
    |-> selftest_active_out) else $error("no self-test");
  AST_ST_OFF: assert property ((!selftest_enable_in)[*4]
    |-> !selftest_active_out) else $error("stray self-test");
  AST_STRAP: assert property (device_enabled_out && $past(device_enabled_out)
    |-> $stable(mode_strap_zero_out)) else $error("strap moved");
  AST_PULL: assert property (device_enabled_out |-> pin4_oe_n_out)
    else $error("pull-low while on");
  AST_GPIO: assert property (!pin16_oe_n_out
    |-> pin16_out == $past(fast_gpio_three_core_in) && device_enabled_out)
    else $error("pin16 value");
  AST_WB: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out
    |=> wb_ack_out != wb_err_out) else $error("no answer");
  cover property ($rose(device_enabled_out));
  cover property (!pin4_oe_n_out);
  cover property (wb_err_out);
endmodule

bind pdsc_top pdsc_checker i_pdsc_checker (.*);

// >>> verif/pdsc_host.sv
// Host GPIO model driving the control pins
module pdsc_host (
  input wire clk_in,
  input wire pin4_oe_n_in,
  output logic pdn_out = 1'h0,
  output logic st_out = 1'h0,
  output wire pin4_out,
  output logic [1:0] s0_out = 2'h0,
  output logic [1:0] s1_out = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p4 = 1'h0; // Host level on pin 4
  int up_cnt = 0; // Cycles since supplies came on
  // Block pull-low beats the weak host level
  assign pin4_out = pin4_oe_n_in ? p4 : 1'h0;
  always @(posedge clk_in) up_cnt <= up_cnt + 1;
  // Release waits for good supplies
  task automatic drive(input logic pd, st, v4, input logic [1:0] a, b);
    while (pd && up_cnt < 8) @(posedge clk_in);
    @(posedge clk_in);
    {pdn_out, st_out, p4, s0_out, s1_out} <= {pd, st, v4, a, b};
  endtask
endmodule

// >>> verif/pdsc_top_tb_top.sv
// Testbench for the power-down and self-test control block
module pdsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'h0, rst_n_in = 1'h0, spi_cs_core_in = 1'h0, host_cs = 1'h1, got_err;
  logic fast_gpio_three_core_in = 1'h0, fast_gpio_three_core_oe_in = 1'h0;
  logic wb_we_in = 1'h0, wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_ack_out, wb_err_out;
  logic [3:0] wb_sel_in = 4'hF;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
  logic power_down_n_in, selftest_enable_in, pin4_in, pin4_out, pin4_oe_n_out, pin16_in;
  logic pin16_out, pin16_oe_n_out, spi_cs_core_out, fast_gpio_three_core_out, pll_enable_out;
  logic se_outputs_oe_n_out, device_enabled_out, core_reset_out, selftest_active_out;
  logic selftest_clock_select_out, interrupt_request_out;
  logic [1:0] mode_strap_zero_in, mode_strap_one_in, mode_strap_zero_out, mode_strap_one_out;
  int error_cnt = 0, n_compared = 0;
  // Pin 16 wire: block drive, else host chip select
  assign pin16_in = pin16_oe_n_out ? host_cs : pin16_out;
  always #12.5 clk_in = ~clk_in;
  pdsc_top i_pdsc_top (.*);
  pdsc_host i_pdsc_host (.clk_in, .pin4_oe_n_in(pin4_oe_n_out), .pdn_out(power_down_n_in),
    .st_out(selftest_enable_in), .pin4_out(pin4_in), .s0_out(mode_strap_zero_in),
    .s1_out(mode_strap_one_in));
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Classic single cycle; waits for ack or err
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, we, adr, wd};
    // No cycle limit here: only the watchdog ends a wait
    do @(posedge clk_in); while (wb_ack_out !== 1'h1 && wb_err_out !== 1'h1);
    {rd, got_err} = {wb_dat_out, wb_err_out};
    {wb_cyc_in, wb_stb_in} <= 2'h0;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'h1;
    // Host holds pin 4 high, so only the pull-low can bring it down
    i_pdsc_host.drive(1'h0, 1'h0, 1'h1, 2'h0, 2'h0);
    wb(1'h1, 8'h00, 32'h4);
    repeat (3) @(posedge clk_in);
    chk({pin4_in, pin4_oe_n_out, pin4_out}, 3'h0);
    wb(1'h0, 8'h04, 32'h0);
    chk({rd[8:0], se_outputs_oe_n_out, core_reset_out}, 11'h003);
    i_pdsc_host.drive(1'h1, 1'h1, 1'h1, 2'h2, 2'h1);
    repeat (6) @(posedge clk_in);
    wb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    wb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h67);
    i_pdsc_host.drive(1'h1, 1'h0, 1'h0, 2'h1, 2'h3);
    repeat (5) @(posedge clk_in);
    chk({mode_strap_zero_out, mode_strap_one_out}, 4'h9);
    chk({interrupt_request_out, selftest_active_out}, 2'h2);
    chk(core_reset_out, 1'h0);
    wb(1'h1, 8'h00, 32'h1);
    for (int v = 0; v < 2; v++) begin
      i_pdsc_host.drive(1'h1, 1'h1, v[0], 2'h1, 2'h3);
      repeat (5) @(posedge clk_in);
      chk({selftest_clock_select_out, interrupt_request_out}, {v[0], 1'h0});
    end
    wb(1'h1, 8'h00, 32'h2);
    {fast_gpio_three_core_oe_in, fast_gpio_three_core_in} <= 2'h3;
    repeat (4) @(posedge clk_in);
    chk({pin16_oe_n_out, pin16_out, spi_cs_core_out, fast_gpio_three_core_out}, 4'h7);
    wb(1'h1, 8'h00, 32'h0);
    host_cs <= 1'h0;
    repeat (4) @(posedge clk_in);
    chk({pin16_oe_n_out, spi_cs_core_out, fast_gpio_three_core_out}, 3'h4);
    wb(1'h0, 8'h08, 32'h0);
    chk(got_err, 1'h1);
    wb(1'h1, 8'h00, 32'h4);
    i_pdsc_host.drive(1'h0, 1'h0, 1'h1, 2'h0, 2'h0);
    repeat (6) @(posedge clk_in);
    chk({device_enabled_out, pll_enable_out, se_outputs_oe_n_out, pin4_oe_n_out}, 4'h2);
    chk(core_reset_out, 1'h1);
    i_pdsc_host.drive(1'h1, 1'h0, 1'h1, 2'h3, 2'h0);
    repeat (6) @(posedge clk_in);
    wb(1'h0, 8'h00, 32'h0);
    chk({rd, mode_strap_zero_out}, {32'h0, 2'h3});
    tally_and_finish();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule
